// ===== rtl/fps_pkg.sv
// constants, register map, flag indices and states of the primary fault sequencer
// assumes a single 125 MHz clock; every analog comparison arrives as a synchronous bit
package fps_pkg;

  // clock
  localparam longint CLK_MHZ            = 125;

  // times in ns
  localparam longint SHORT_LEB_NS       = 250;
  localparam longint NORMAL_LEB_NS      = 400;
  localparam longint SENSE_WIN_NS       = 4500;
  localparam longint OVP_VALID_NS       = 10000;
  localparam longint BLANK_INTERVAL_NS  = 1000000;
  localparam longint STARTUP_TIMEOUT_NS = 55000000;
  localparam longint LINE_LOW_NS        = 50000000;
  localparam longint EXT_INTERVAL_NS    = 150000;
  localparam longint EXT_TRIP_NS        = 300000;
  localparam longint EXT_BIAS_NS        = 5000;

  // derived cycle counts, least times rounded up
  localparam int SHORT_LEB_CYC       = int'((SHORT_LEB_NS * CLK_MHZ + 999) / 1000);
  localparam int NORMAL_LEB_CYC      = int'((NORMAL_LEB_NS * CLK_MHZ + 999) / 1000);
  localparam int SENSE_WIN_CYC       = int'((SENSE_WIN_NS * CLK_MHZ + 999) / 1000);
  localparam int OVP_VALID_CYC       = int'((OVP_VALID_NS * CLK_MHZ + 999) / 1000);
  localparam int BLANK_INTERVAL_CYC  = int'((BLANK_INTERVAL_NS * CLK_MHZ + 999) / 1000);
  localparam int STARTUP_TIMEOUT_CYC = int'((STARTUP_TIMEOUT_NS * CLK_MHZ + 999) / 1000);
  localparam int LINE_LOW_CYC        = int'((LINE_LOW_NS * CLK_MHZ + 999) / 1000);
  localparam int EXT_INTERVAL_CYC    = int'((EXT_INTERVAL_NS * CLK_MHZ + 999) / 1000);
  localparam int EXT_TRIP_CYC        = int'((EXT_TRIP_NS * CLK_MHZ + 999) / 1000);
  localparam int EXT_BIAS_CYC        = int'((EXT_BIAS_NS * CLK_MHZ + 999) / 1000);

  // switching-cycle counts
  localparam int SC_RETRY_CYCLES     = 8;
  localparam int SENSE_CHECK_CYCLES  = 4;

  // register map
  localparam logic [7:0]  REG_CTRL_OFS   = 8'h00;
  localparam logic [7:0]  REG_STATUS_OFS = 8'h04;
  localparam logic [31:0] CTRL_RESET     = 32'h0000_0003;
  localparam int          CTRL_RUN_BIT   = 0;
  localparam int          CTRL_EXT_BIT   = 1;
  localparam int          STAT_FLAG_LSB  = 0;
  localparam int          STAT_GATE_BIT  = 12;
  localparam int          STAT_HV_BIT    = 13;
  localparam int          STAT_ARM_BIT   = 14;
  localparam int          STAT_LEB_BIT   = 15;
  localparam int          STAT_STATE_LSB = 16;

  // fault flag positions
  localparam int FLG_SHORT     = 0;
  localparam int FLG_SENSE_SH  = 1;
  localparam int FLG_SENSE_OP  = 2;
  localparam int FLG_SUPPLY_HI = 3;
  localparam int FLG_LINE_LOW  = 4;
  localparam int FLG_THERMAL   = 5;
  localparam int FLG_STARTUP   = 6;
  localparam int FLG_EXTERNAL  = 7;
  localparam int FLG_SECONDARY = 8;
  localparam int NUM_FLAGS     = 9;

  localparam logic [1:0] HTRANS_NONSEQ_BIT = 2'h2;

  typedef enum logic [2:0] {
    ST_IDLE, ST_CHARGE, ST_SOFT, ST_RUN, ST_SC_BLANK, ST_PROTECT
  } fps_state_t;

endpackage : fps_pkg

// ===== rtl/fps_if.sv
// bundles between the sequencer and its timer and sampler helpers
// assumes both ends share ref_clk
interface fps_qual_if;
  logic run;
  logic expired;
  modport timer (input run, output expired);
  modport user  (output run, input expired);
endinterface : fps_qual_if

interface fps_ext_if;
  logic enable;
  logic belowTrip;
  logic biasEn;
  logic trip;
  modport sampler (input enable, input belowTrip, output biasEn, output trip);
  modport user    (output enable, output belowTrip, input biasEn, input trip);
endinterface : fps_ext_if

// ===== rtl/fps_qual_timer.sv
// qualifying timer: expired rises once run has held for CYCLES clocks
// assumes run is synchronous to ref_clk; dropping run restarts the count
module fps_qual_timer #(
  parameter int CYCLES = 8
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // control
  fps_qual_if.timer q
);
  localparam int CW = $clog2(CYCLES + 1);

  if (CYCLES < 1) begin : g_chk
    $error("fps_qual_timer: CYCLES must be at least 1");
  end

  logic [CW-1:0] cnt_ff;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_ff <= '0;
    end else if (!q.run) begin
      cnt_ff <= '0;
    end else if (cnt_ff != CW'(CYCLES)) begin
      cnt_ff <= cnt_ff + CW'(1);
    end
  end

  assign q.expired = (cnt_ff == CW'(CYCLES));

endmodule : fps_qual_timer

// ===== rtl/fps_ext_sampler.sv
// external-protect sampler: biases the pin briefly each interval and times low samples
// assumes belowTrip is valid while biasEn is high
module fps_ext_sampler #(
  parameter int INTERVAL = 18750,
  parameter int BIAS     = 625,
  parameter int TRIP     = 37500
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // pin side
  fps_ext_if.sampler ext
);
  localparam int IW = $clog2(INTERVAL);
  localparam int LW = $clog2(TRIP + INTERVAL + 1);

  if (BIAS < 1 || BIAS >= INTERVAL || TRIP < 1) begin : g_chk
    $error("fps_ext_sampler: need 1 <= BIAS < INTERVAL and TRIP >= 1");
  end

  logic [IW-1:0] phase_ff;
  logic [LW-1:0] lowTime_ff;
  logic          biasEn_ff;
  logic          sampleNow;

  assign sampleNow = ext.enable && (phase_ff == IW'(BIAS - 1));

  // interval phase and bias window
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      phase_ff  <= '0;
      biasEn_ff <= 1'b0;
    end else if (!ext.enable) begin
      phase_ff  <= '0;
      biasEn_ff <= 1'b0;
    end else begin
      phase_ff  <= (phase_ff == IW'(INTERVAL - 1)) ? '0 : phase_ff + IW'(1);
      biasEn_ff <= (phase_ff == IW'(INTERVAL - 1)) || (phase_ff < IW'(BIAS - 1));
    end
  end

  // continuous low time, one interval per low sample
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      lowTime_ff <= '0;
    end else if (!ext.enable) begin
      lowTime_ff <= '0;
    end else if (sampleNow) begin
      if (!ext.belowTrip) begin
        lowTime_ff <= '0;
      end else if (lowTime_ff <= LW'(TRIP)) begin
        lowTime_ff <= lowTime_ff + LW'(INTERVAL);
      end
    end
  end

  assign ext.biasEn = biasEn_ff;
  assign ext.trip   = (lowTime_ff > LW'(TRIP));

endmodule : fps_ext_sampler

// ===== rtl/fps_fault_sequencer.sv
// primary-side fault supervisor and auto-restart sequencer with an AHB-Lite register slave
// assumes all comparator and link inputs are already synchronous to ref_clk
module fps_fault_sequencer
  import fps_pkg::*;
#(
  parameter int STARTUP_CYCLES  = STARTUP_TIMEOUT_CYC,
  parameter int LINE_LOW_CYCLES = LINE_LOW_CYC,
  parameter int BLANK_CYCLES    = BLANK_INTERVAL_CYC,
  parameter int EXT_INTERVAL    = EXT_INTERVAL_CYC,
  parameter int EXT_TRIP        = EXT_TRIP_CYC,
  parameter int OVP_CYCLES      = OVP_VALID_CYC
) (
  // clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 resetn,
  // ahb-lite slave
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output      logic                 hreadyout,
  output      logic                 hresp,
  output      logic [31:0]          hrdata,
  // supply and line comparators
  input  wire logic                 supplyBelowMin,
  input  wire logic                 supplyAtRestart,
  input  wire logic                 supplyChargeDone,
  input  wire logic                 supplyAboveHigh,
  input  wire logic                 lineLow,
  // thermal indications
  input  wire logic                 thermalHot,
  input  wire logic                 thermalCool,
  // current sense comparators and modulator
  input  wire logic                 senseAboveShort,
  input  wire logic                 senseAboveMin,
  input  wire logic                 gateHigh,
  input  wire logic                 turnOnPulse,
  // secondary link
  input  wire logic                 secStartup,
  input  wire logic                 secProtect,
  // external protect pin
  input  wire logic                 extBelowTrip,
  output      logic                 extBiasEn,
  // primary control
  output      logic                 switchEnable,
  output      logic                 hvSourceEn,
  output      logic                 peakLebShort,
  output      logic [NUM_FLAGS-1:0] faultFlags
);
  localparam int BW  = $clog2(BLANK_CYCLES + 1);
  localparam int LBW = $clog2(NORMAL_LEB_CYC + 1);
  localparam int SWW = $clog2(SENSE_WIN_CYC + 1);
  localparam int RW  = $clog2(SC_RETRY_CYCLES + 1);
  localparam int CKW = $clog2(SENSE_CHECK_CYCLES + 1);

  if (BLANK_CYCLES < 1 || STARTUP_CYCLES < 1 || LINE_LOW_CYCLES < 1 || OVP_CYCLES < 1) begin : g_chk
    $error("fps_fault_sequencer: timing counts must be at least 1");
  end

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  fps_state_t           state_ff, nxt_state;
  logic [NUM_FLAGS-1:0] flags_ff, nxt_flags;
  logic [31:0]          ctrl_ff;
  logic [31:0]          hrdata_ff;
  logic                 wrPend_ff;
  logic [7:0]           wrAddr_ff;
  logic                 switchEn_ff;
  logic                 hvEn_ff;
  logic                 scArmed_ff;
  logic                 scCounting_ff;
  logic [RW-1:0]        scCnt_ff;
  logic [BW-1:0]        blankCnt_ff;
  logic                 retRun_ff;
  logic [LBW-1:0]       lebCnt_ff;
  logic                 ssActive_ff;
  logic                 ssSeen_ff;
  logic [SWW-1:0]       ssCnt_ff;
  logic [CKW-1:0]       ssChecks_ff;
  logic                 peakShort_ff;

  logic operating;
  logic anyFlag;
  logic scValid;
  logic scFirst;
  logic scSecond;
  logic blankDone;
  logic ssFail;
  logic restartNow;
  logic addrPhase;
  logic [31:0] statusWord;
  logic [31:0] rdMux;

  fps_qual_if startupQ ();
  fps_qual_if lineQ ();
  fps_qual_if ovpQ ();
  fps_ext_if  extQ ();

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  assign operating = (state_ff == ST_SOFT) || (state_ff == ST_RUN) || (state_ff == ST_SC_BLANK);
  assign anyFlag   = |flags_ff;

  assign startupQ.run = (state_ff == ST_SOFT);
  assign lineQ.run    = operating && lineLow;
  assign ovpQ.run     = supplyAboveHigh && (state_ff != ST_IDLE);

  assign extQ.enable    = operating && ctrl_ff[CTRL_EXT_BIT];
  assign extQ.belowTrip = extBelowTrip;

  fps_qual_timer #(.CYCLES(STARTUP_CYCLES)) u_startup (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .q       (startupQ)
  );

  fps_qual_timer #(.CYCLES(LINE_LOW_CYCLES)) u_linelow (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .q       (lineQ)
  );

  fps_qual_timer #(.CYCLES(OVP_CYCLES)) u_ovp (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .q       (ovpQ)
  );

  fps_ext_sampler #(
    .INTERVAL (EXT_INTERVAL),
    .BIAS     (EXT_BIAS_CYC),
    .TRIP     (EXT_TRIP)
  ) u_ext (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .ext     (extQ)
  );

  ////////////////////////////////////////////////////////////////////////////
  // blanking after turn-on

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      lebCnt_ff <= '0;
    end else if (turnOnPulse) begin
      lebCnt_ff <= '0;
    end else if (lebCnt_ff != LBW'(NORMAL_LEB_CYC)) begin
      lebCnt_ff <= lebCnt_ff + LBW'(1);
    end
  end

  // short comparator always uses the short blanking
  assign scValid  = gateHigh && senseAboveShort && !turnOnPulse && (lebCnt_ff >= LBW'(SHORT_LEB_CYC));
  assign scFirst  = scValid && (state_ff == ST_RUN) && !scArmed_ff;
  assign scSecond = scValid && (state_ff == ST_RUN) && scArmed_ff;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      peakShort_ff <= 1'b0;
    end else begin
      peakShort_ff <= scArmed_ff || scFirst;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // short-circuit blanking and retry window

  assign blankDone = (state_ff == ST_SC_BLANK) && (blankCnt_ff == BW'(BLANK_CYCLES - 1));

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      blankCnt_ff <= '0;
    end else if (state_ff == ST_SC_BLANK) begin
      blankCnt_ff <= blankCnt_ff + BW'(1);
    end else begin
      blankCnt_ff <= '0;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      scArmed_ff    <= 1'b0;
      scCounting_ff <= 1'b0;
      scCnt_ff      <= '0;
    end else if (scFirst) begin
      scArmed_ff    <= 1'b1;
      scCounting_ff <= 1'b0;
      scCnt_ff      <= '0;
    end else if (!operating) begin
      scArmed_ff    <= 1'b0;
      scCounting_ff <= 1'b0;
      scCnt_ff      <= '0;
    end else if (blankDone) begin
      scCounting_ff <= 1'b1;
    end else if (scCounting_ff && turnOnPulse) begin
      if (scCnt_ff == RW'(SC_RETRY_CYCLES - 1)) begin
        scArmed_ff    <= 1'b0;
        scCounting_ff <= 1'b0;
        scCnt_ff      <= '0;
      end else begin
        scCnt_ff <= scCnt_ff + RW'(1);
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      retRun_ff <= 1'b0;
    end else if (state_ff == ST_CHARGE) begin
      retRun_ff <= 1'b0;
    end else if (state_ff == ST_RUN) begin
      retRun_ff <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sense-short window in the first switching cycles

  assign ssFail = ssActive_ff && (ssCnt_ff == SWW'(SENSE_WIN_CYC - 1)) && !ssSeen_ff && !senseAboveMin;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ssActive_ff <= 1'b0;
      ssSeen_ff   <= 1'b0;
      ssCnt_ff    <= '0;
      ssChecks_ff <= '0;
    end else if (!operating) begin
      ssActive_ff <= 1'b0;
      ssSeen_ff   <= 1'b0;
      ssCnt_ff    <= '0;
      ssChecks_ff <= '0;
    end else if (turnOnPulse && ssChecks_ff != CKW'(SENSE_CHECK_CYCLES)) begin
      ssActive_ff <= 1'b1;
      ssSeen_ff   <= 1'b0;
      ssCnt_ff    <= '0;
      ssChecks_ff <= ssChecks_ff + CKW'(1);
    end else if (ssActive_ff) begin
      ssSeen_ff <= ssSeen_ff || senseAboveMin;
      ssCnt_ff  <= ssCnt_ff + SWW'(1);
      if (ssCnt_ff == SWW'(SENSE_WIN_CYC - 1)) begin
        ssActive_ff <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // fault flags: clears first, sets last so a set wins

  assign restartNow = (state_ff == ST_PROTECT) && supplyAtRestart;

  always_comb begin
    nxt_flags = flags_ff;
    if (restartNow) begin
      nxt_flags = flags_ff & (NUM_FLAGS'(1) << FLG_THERMAL);
    end
    if (thermalCool) begin
      nxt_flags[FLG_THERMAL] = 1'b0;
    end
    if (scSecond && scCounting_ff) begin
      nxt_flags[FLG_SHORT] = 1'b1;
    end
    if (scValid && state_ff == ST_SOFT) begin
      nxt_flags[FLG_SENSE_OP] = 1'b1;
    end
    if (ssFail) begin
      nxt_flags[FLG_SENSE_SH] = 1'b1;
    end
    if (ovpQ.expired) begin
      nxt_flags[FLG_SUPPLY_HI] = 1'b1;
    end
    if (lineQ.expired) begin
      nxt_flags[FLG_LINE_LOW] = 1'b1;
    end
    if (thermalHot) begin
      nxt_flags[FLG_THERMAL] = 1'b1;
    end
    if (startupQ.expired) begin
      nxt_flags[FLG_STARTUP] = 1'b1;
    end
    if (extQ.trip) begin
      nxt_flags[FLG_EXTERNAL] = 1'b1;
    end
    if (secProtect && state_ff != ST_IDLE && state_ff != ST_PROTECT) begin
      nxt_flags[FLG_SECONDARY] = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      flags_ff <= '0;
    end else begin
      flags_ff <= nxt_flags;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_IDLE: begin
        if (ctrl_ff[CTRL_RUN_BIT]) nxt_state = ST_CHARGE;
      end
      ST_CHARGE: begin
        if (!ctrl_ff[CTRL_RUN_BIT]) nxt_state = ST_IDLE;
        else if (anyFlag) nxt_state = ST_PROTECT;
        else if (supplyChargeDone && !lineLow && !supplyBelowMin) nxt_state = secStartup ? ST_RUN : ST_SOFT;
      end
      ST_SOFT: begin
        if (anyFlag) nxt_state = ST_PROTECT;
        else if (supplyBelowMin) nxt_state = ST_CHARGE;
        else if (secStartup) nxt_state = ST_RUN;
      end
      ST_RUN: begin
        if (anyFlag) nxt_state = ST_PROTECT;
        else if (supplyBelowMin) nxt_state = ST_CHARGE;
        else if (scFirst) nxt_state = ST_SC_BLANK;
      end
      ST_SC_BLANK: begin
        if (anyFlag) nxt_state = ST_PROTECT;
        else if (supplyBelowMin) nxt_state = ST_CHARGE;
        else if (blankDone) nxt_state = retRun_ff ? ST_RUN : ST_SOFT;
      end
      ST_PROTECT: begin
        if (restartNow && !nxt_flags[FLG_THERMAL]) nxt_state = ST_CHARGE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      switchEn_ff <= 1'b0;
      hvEn_ff     <= 1'b0;
    end else begin
      switchEn_ff <= (nxt_state == ST_SOFT || nxt_state == ST_RUN) && !(|nxt_flags);
      hvEn_ff     <= (nxt_state == ST_CHARGE);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // ahb-lite register slave, zero wait states

  assign addrPhase = hsel && hready && htrans[1] && (htrans & HTRANS_NONSEQ_BIT) != 2'h0;

  always_comb begin
    statusWord = '0;
    statusWord[STAT_FLAG_LSB +: NUM_FLAGS] = flags_ff;
    statusWord[STAT_GATE_BIT]              = switchEn_ff;
    statusWord[STAT_HV_BIT]                = hvEn_ff;
    statusWord[STAT_ARM_BIT]               = scArmed_ff;
    statusWord[STAT_LEB_BIT]               = peakShort_ff;
    statusWord[STAT_STATE_LSB +: 3]        = state_ff;
    unique case (haddr[7:0])
      REG_CTRL_OFS:   rdMux = ctrl_ff;
      REG_STATUS_OFS: rdMux = statusWord;
      default:        rdMux = '0;
    endcase
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wrPend_ff <= 1'b0;
      wrAddr_ff <= '0;
      hrdata_ff <= '0;
    end else begin
      wrPend_ff <= addrPhase && hwrite && (haddr[31:8] == 24'h000000);
      wrAddr_ff <= haddr[7:0];
      if (addrPhase && !hwrite) begin
        hrdata_ff <= (haddr[31:8] == 24'h000000) ? rdMux : '0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_ff <= CTRL_RESET;
    end else if (wrPend_ff && wrAddr_ff == REG_CTRL_OFS) begin
      ctrl_ff <= {30'h0, hwdata[CTRL_EXT_BIT], hwdata[CTRL_RUN_BIT]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign hreadyout    = 1'b1;
  assign hresp        = 1'b0;
  assign hrdata       = hrdata_ff;
  assign switchEnable = switchEn_ff;
  assign hvSourceEn   = hvEn_ff;
  assign peakLebShort = peakShort_ff;
  assign faultFlags   = flags_ff;
  assign extBiasEn    = extQ.biasEn;

endmodule : fps_fault_sequencer

// ===== sim/fps_seq_chk.sv
// assertions on the fault sequencer top ports
// assumes one clock domain; bound at the foot of this file
module fps_seq_chk
  import fps_pkg::*;
#(parameter int OVP_CYCLES = 20) (
  // clock and reset
  input wire logic                 ref_clk,
  input wire logic                 resetn,
  // watched inputs
  input wire logic                 supplyBelowMin,
  input wire logic                 supplyAtRestart,
  input wire logic                 supplyAboveHigh,
  input wire logic                 thermalHot,
  input wire logic                 thermalCool,
  // watched outputs
  input wire logic                 extBiasEn,
  input wire logic                 switchEnable,
  input wire logic                 hvSourceEn,
  input wire logic                 peakLebShort,
  input wire logic [NUM_FLAGS-1:0] faultFlags
);
  int ovpCnt_ff;
  int biasCnt_ff;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // run lengths of supply-high and bias-on
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ovpCnt_ff  <= 0;
      biasCnt_ff <= 0;
    end else begin
      ovpCnt_ff  <= supplyAboveHigh ? ovpCnt_ff + 1 : 0;
      biasCnt_ff <= extBiasEn ? biasCnt_ff + 1 : 0;
    end
  end
  ////////////////////////////////////////////////////////////////
  a_flag_gate: assert property (|faultFlags |-> !switchEnable) else $error("switching with a flag");
  a_supply_low_lockout_gate: assert property (supplyBelowMin |=> !switchEnable) else $error("switching below min");
  a_supply_low_lockout_charge: assert property ($rose(supplyBelowMin) && switchEnable |-> ##[1:4] hvSourceEn)
    else $error("no recharge");
  a_hot_stop: assert property (thermalHot |=> faultFlags[FLG_THERMAL] && !switchEnable)
    else $error("thermal not stopped");
  a_hot_hold: assert property (faultFlags[FLG_THERMAL] && !thermalCool |=> faultFlags[FLG_THERMAL])
    else $error("thermal flag dropped");
  a_flag_latch: assert property (!$past(supplyAtRestart) |-> (~faultFlags & $past(faultFlags) & 9'h1df) == 9'h000)
    else $error("flag dropped early");
  a_ovp_valid: assert property (ovpCnt_ff == OVP_CYCLES |-> ##[0:3] faultFlags[FLG_SUPPLY_HI])
    else $error("supply high missed");
  a_bias_brief: assert property (biasCnt_ff <= EXT_BIAS_CYC) else $error("bias on too long");
  a_leb_short: assert property ($rose(peakLebShort) |-> !switchEnable) else $error("short leb outside blank");
  c_short: cover property (faultFlags[FLG_SHORT]);
  c_blank: cover property ($rose(peakLebShort));
  c_ext: cover property (faultFlags[FLG_EXTERNAL]);
endmodule : fps_seq_chk

bind fps_fault_sequencer fps_seq_chk #(.OVP_CYCLES(OVP_CYCLES)) chk (.ref_clk, .resetn, .supplyBelowMin,
  .supplyAtRestart, .supplyAboveHigh, .thermalHot, .thermalCool, .extBiasEn, .switchEnable, .hvSourceEn,
  .peakLebShort, .faultFlags);

// ===== sim/fps_sec_model.sv
// secondary-side controller model on the link
// assumes the secondary is unpowered while the primary recharges
module fps_sec_model (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  // primary state and bench control
  input  wire logic        hvSourceEn,
  input  wire logic [31:0] delay,
  input  wire logic        protReq,
  // link
  output logic             secStartup,
  output logic             secProtect
);
  logic [31:0] cnt;
  // start-up signal after a settable delay
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cnt        <= '0;
      secStartup <= 1'b0;
      secProtect <= 1'b0;
    end else begin
      cnt        <= hvSourceEn ? '0 : cnt + 1;
      secStartup <= !hvSourceEn && cnt >= delay;
      secProtect <= protReq;
    end
  end
endmodule : fps_sec_model

// ===== sim/fps_tb.sv
// self-checking bench for the primary fault sequencer
// assumes the secondary model on the link and shortened timers
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {logic [7:0] d; int hold; int dl; logic [8:0] exp;} fps_row_t;
  logic        ref_clk = 0, resetn = 0, hsel = 0, hwrite = 0, supplyAtRestart = 0, thermalCool = 0;
  logic        turnOnPulse = 0, gateHigh = 0, senseAboveMin = 0, senseAboveShort = 0, chargeDone = 1;
  logic        hreadyout, hresp, secStartup, secProtect, extBiasEn, switchEnable, hvSourceEn, peakLebShort;
  logic [1:0]  htrans = 0;
  logic [2:0]  hsize = 3'h2;
  logic [7:0]  drv = 0;
  logic [8:0]  faultFlags;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd, dly = 10;
  int          mismatches, nChecks, cyc, ph, i;
  fps_row_t rows [9] = '{'{8'h01, 2, 10, 9'h020}, '{8'h02, 5, 10, 9'h100}, '{8'h04, 1300, 10, 9'h008},
    '{8'h08, 250, 10, 9'h010}, '{8'h10, 3500, 10, 9'h080}, '{8'h20, 900, 10, 9'h002}, '{8'h80, 3, 10, 9'h000},
    '{8'h00, 300, 99999, 9'h040}, '{8'h40, 60, 99999, 9'h004}};
  fps_fault_sequencer #(.STARTUP_CYCLES(200), .LINE_LOW_CYCLES(200), .BLANK_CYCLES(50), .EXT_INTERVAL(700),
    .EXT_TRIP(1000)) dut (.ref_clk, .resetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .supplyBelowMin(drv[7]), .supplyAtRestart,
    .supplyChargeDone(chargeDone), .supplyAboveHigh(drv[2]), .lineLow(drv[3]), .thermalHot(drv[0]), .thermalCool,
    .senseAboveShort, .senseAboveMin, .gateHigh, .turnOnPulse, .secStartup, .secProtect, .extBelowTrip(drv[4]),
    .extBiasEn, .switchEnable, .hvSourceEn, .peakLebShort, .faultFlags);
  fps_sec_model sec (.ref_clk, .resetn, .hvSourceEn, .delay(dly), .protReq(drv[1]), .secStartup, .secProtect);
  ////////////////////////////////////////////////////////////////
  initial forever #4 ref_clk = ~ref_clk;
  // modulator stand-in: 80-cycle period, gate on 60
  always @(posedge ref_clk) begin
    ph              <= (switchEnable !== 1'b1 || ph == 79) ? 0 : ph + 1;
    turnOnPulse     <= switchEnable && ph == 0;
    gateHigh        <= switchEnable && ph < 60;
    senseAboveMin   <= switchEnable && ph > 5 && ph < 60 && !drv[5];
    senseAboveShort <= switchEnable && ph > 40 && ph < 60 && drv[6];
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 40000) begin
      mismatches++;
      give_verdict();
    end
  end
  task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
    nChecks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic clk(int n);
    repeat (n) @(posedge ref_clk);
  endtask : clk
  task automatic ahb(logic wr, logic [31:0] a, logic [31:0] wd, output logic [31:0] r);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= wr;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : ahb
  // supply dip, then wait for switching
  task automatic start_up(int d);
    dly <= d;
    drv <= 8'h80;
    clk(3);
    chk("recharge", hvSourceEn, 1);
    drv <= 8'h00;
    for (i = 0; i < 2000 && switchEnable !== 1'b1; i++) clk(1);
    chk("switching", switchEnable, 1);
    clk(20);
  endtask : start_up
  task automatic restart();
    clk(3);
    thermalCool     <= 1'b1;
    supplyAtRestart <= 1'b1;
    clk(4);
    chk("cleared", faultFlags, 0);
    thermalCool     <= 1'b0;
    supplyAtRestart <= 1'b0;
  endtask : restart
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", nChecks, mismatches);
    if (mismatches == 0 && nChecks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : give_verdict
  initial begin
    clk(8);
    resetn <= 1'b1;
    clk(1);
    chk("reset flags", faultFlags, 0);
    ahb(0, 32'h0, 0, rd);
    chk("ctrl", rd, fps_pkg::CTRL_RESET);
    ahb(1, 32'h0, 32'hffff_fffc, rd);
    ahb(0, 32'h0, 0, rd);
    chk("ctrl", rd, 0);
    ahb(1, 32'h0, 32'h3, rd);
    ahb(0, 32'h10, 0, rd);
    chk("unmapped", rd, 0);
    chk("okay", hresp, 0);
    $display("test registers done");
    foreach (rows[k]) begin
      start_up(rows[k].dl);
      drv <= rows[k].d;
      clk(rows[k].hold);
      chk("flags", faultFlags, rows[k].exp);
      chk("stopped", switchEnable, 0);
      drv <= 8'h00;
      restart();
      $display("test row %0d done", k);
    end
    chargeDone <= 1'b0;
    drv        <= 8'h80;
    clk(3);
    drv <= 8'h00;
    clk(20);
    chk("charge wait", {switchEnable, hvSourceEn}, 2'h1);
    chargeDone <= 1'b1;
    $display("test charge wait done");
    start_up(10);
    clk(700);
    drv <= 8'h20;
    clk(300);
    chk("late sense", faultFlags, 0);
    drv <= 8'h40;
    for (i = 0; i < 300 && peakLebShort !== 1'b1; i++) clk(1);
    drv <= 8'h00;
    clk(2);
    chk("first short", faultFlags, 0);
    chk("blanked", switchEnable, 0);
    chk("short leb", peakLebShort, 1);
    clk(900);
    chk("leb back", peakLebShort, 0);
    chk("resumed", switchEnable, 1);
    drv <= 8'h40;
    clk(400);
    chk("second short", faultFlags, 9'h001);
    $display("test short circuit done");
    ahb(1, 32'h0, 32'h0, rd);
    resetn <= 1'b0;
    clk(2);
    chk("mid reset", {faultFlags, switchEnable, hvSourceEn}, 0);
    resetn <= 1'b1;
    clk(2);
    ahb(0, 32'h0, 0, rd);
    chk("ctrl reset", rd, fps_pkg::CTRL_RESET);
    $display("test mid-run reset done");
    give_verdict();
  end
endmodule : testbench
